// >>> fcc_pkg.sv
// package with register map, field positions and timing constants for the flash cache control
package fcc_pkg;

  // ************************************************************
  // register byte addresses
  // ************************************************************
  localparam logic [31:0] FCC_ADDR_STATE  = 32'h400180c0; // cache_state_report
  localparam logic [31:0] FCC_ADDR_CONFIG = 32'h400180c4; // cache_configuration
  localparam logic [31:0] FCC_ADDR_UNLOCK = 32'h400180c8; // cache_unlock_word

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [31:0] FCC_STATE_RST  = 32'h00000002; // state after reset
  localparam logic [31:0] FCC_CONFIG_RST = 32'h00000002; // configuration after reset
  localparam logic [31:0] FCC_UNLOCK_RST = 32'h00000000; // unlock word after reset

  // ************************************************************
  // unlock value and field positions
  // ************************************************************
  localparam logic [31:0] FCC_UNLOCK_KEY  = 32'hf123f456; // value that opens setup writes
  localparam int          FCC_D_WBUF_BIT  = 19;           // data write buffer hit bypass
  localparam int          FCC_D_FREEZE    = 18;           // data cache freeze
  localparam int          FCC_D_ON        = 17;           // data cache on
  localparam int          FCC_D_ZERO      = 16;           // data cache zero fill
  localparam int          FCC_I_RBUF_BIT  = 4;            // instruction read buffer bypass
  localparam int          FCC_I_WBUF_BIT  = 3;            // instruction write buffer bypass
  localparam int          FCC_I_FREEZE    = 2;            // instruction cache freeze
  localparam int          FCC_I_ON        = 1;            // instruction cache on
  localparam int          FCC_I_ZERO      = 0;            // instruction cache zero fill

  // ************************************************************
  // cache geometry and zero fill timing
  // ************************************************************
  localparam int          FCC_LINES       = 16;           // lines per cache
  localparam int          FCC_IDX_W       = 4;            // line index width
  localparam int          FCC_LINE_W      = 32;           // line width
  localparam int          FCC_CLK_MHZ     = 200;          // system clock rate
  localparam int          FCC_FILL_NS     = 80;           // least zero fill time
  localparam int          FCC_FILL_CYC    = (FCC_FILL_NS * FCC_CLK_MHZ + 999) / 1000;

endpackage : fcc_pkg

// >>> fcc_cache_way.sv
// one cache memory: zero fill sequencer and line storage for one cache
`timescale 1ns/10ps
module fcc_cache_way
  import fcc_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  clk_en,
  // control
  input  wire logic                  fill_start,  // one cycle pulse, begins zero fill
  input  wire logic                  cache_on,    // effective enable
  input  wire logic                  freeze,      // misses allocate nothing
  // processor side
  input  wire logic                  acc_valid,   // access request
  input  wire logic [FCC_IDX_W-1:0]  acc_idx,     // line index
  input  wire logic [FCC_LINE_W-1:0] acc_fill,    // line fetched from flash on a miss
  input  wire logic                  acc_miss,    // access missed
  output logic                       filling,     // zero fill in progress
  output logic [FCC_LINE_W-1:0]      line_q       // stored line of last access
);

  // ************************************************************
  // storage and fill state
  // ************************************************************
  logic [FCC_LINE_W-1:0] mem_q [FCC_LINES];  // line storage
  logic [FCC_IDX_W-1:0]  fidx_q;             // fill index
  logic [7:0]            fcnt_q;             // fill time counter
  logic                  fill_q;             // fill busy

  assign filling = fill_q;

  // fill sequencer: clears one line per cycle, stays busy the least fill time
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fill_q <= 1'b0;
      fidx_q <= '0;
      fcnt_q <= '0;
    end else if (clk_en) begin
      if (fill_start) begin
        fill_q <= 1'b1;
        fidx_q <= '0;
        fcnt_q <= 8'(FCC_FILL_CYC - 1);
      end else if (fill_q) begin
        fidx_q <= fidx_q + 4'h1;
        if (fcnt_q == 8'h00 && fidx_q == 4'(FCC_LINES - 1)) begin
          fill_q <= 1'b0;
        end
        if (fcnt_q != 8'h00) begin
          fcnt_q <= fcnt_q - 8'h01;
        end
      end
    end
  end

  // line storage: zero fill wins, then allocation when not frozen
  genvar g;
  generate
    for (g = 0; g < FCC_LINES; g++) begin : g_line
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          mem_q[g] <= '0;
        end else if (clk_en) begin
          if (fill_q && fidx_q == 4'(g)) begin
            mem_q[g] <= '0;
          end else if (!fill_q && cache_on && !freeze && acc_valid && acc_miss
                       && acc_idx == 4'(g)) begin
            mem_q[g] <= acc_fill;
          end
        end
      end
    end
  endgenerate

  // read port: registered line of the last access
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      line_q <= '0;
    end else if (clk_en && acc_valid) begin
      line_q <= mem_q[acc_idx];
    end
  end

endmodule : fcc_cache_way

// >>> fcc_ctrl.sv
// flash cache control: key guarded setup register, live state report, cache sequencing
`timescale 1ns/10ps
// How it works
// - state bit 18 shows data freeze
// - state bit 17 data on, cleared during fill
// - state bit 16 high during data fill
// - state bit 2 shows instruction freeze
// - state bit 1 instruction on, resets one
// - state bit 0 high during instruction fill
// - setup writes need unlock key first
// - unlock word reads back as zero
// - setup write clears stored unlock word
// - bits 19, 4, 3 bypass buffer checks
// - data freeze stops allocation, cleared by fill
// - data on bit, cleared by fill
// - data fill bit self clears on start
// - instruction freeze, cleared by fill
// - instruction on, resets one, cleared by fill
// - instruction fill bit self clears on start
module fcc_ctrl
  import fcc_pkg::*;
(
  // clock, enable and reset
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  clk_en,
  // register port
  input  wire logic [31:0]           reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  // instruction fetch path
  input  wire logic                  i_valid,
  input  wire logic [FCC_IDX_W-1:0]  i_idx,
  input  wire logic                  i_miss,
  input  wire logic [FCC_LINE_W-1:0] i_fill,
  output logic      [FCC_LINE_W-1:0] i_line,
  // data path
  input  wire logic                  d_valid,
  input  wire logic [FCC_IDX_W-1:0]  d_idx,
  input  wire logic                  d_miss,
  input  wire logic [FCC_LINE_W-1:0] d_fill,
  output logic      [FCC_LINE_W-1:0] d_line,
  // routing controls toward the flash path
  output logic                       i_use_cache,
  output logic                       d_use_cache,
  output logic                       i_alloc_ok,
  output logic                       d_alloc_ok,
  output logic                       i_rbuf_skip,
  output logic                       i_wbuf_skip,
  output logic                       d_wbuf_skip
);

  // ************************************************************
  // registers
  // ************************************************************
  logic [31:0]           cfg_q;          // cache_configuration
  logic [31:0]           key_q;          // cache_unlock_word
  logic [31:0]           stat_q;         // cache_state_report
  logic                  i_start_q;      // instruction fill start pulse
  logic                  d_start_q;      // data fill start pulse
  logic                  i_filling;      // instruction fill busy
  logic                  d_filling;      // data fill busy
  logic [FCC_LINE_W-1:0] i_line_w;       // instruction line from storage
  logic [FCC_LINE_W-1:0] d_line_w;       // data line from storage
  logic                  unlocked;       // key holds unlock value
  logic                  cfg_wr;         // setup write strobe
  logic                  key_wr;         // key write strobe

  // address decode shared by read and write paths
  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a == r);
  endfunction : hit

  assign unlocked = (key_q == FCC_UNLOCK_KEY);
  assign cfg_wr   = reg_wr && hit(reg_addr, FCC_ADDR_CONFIG);
  assign key_wr   = reg_wr && hit(reg_addr, FCC_ADDR_UNLOCK);

  // ************************************************************
  // unlock word
  // ************************************************************
  // unlock word: loaded by key writes, wiped after any setup write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      key_q <= FCC_UNLOCK_RST;
    end else if (clk_en) begin
      if (cfg_wr) begin
        key_q <= FCC_UNLOCK_RST;
      end else if (key_wr) begin
        key_q <= reg_wdata;
      end
    end
  end

  // ************************************************************
  // setup register
  // ************************************************************
  // setup register: guarded write, fill bits clear their dependants and themselves
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q     <= FCC_CONFIG_RST;
      i_start_q <= 1'b0;
      d_start_q <= 1'b0;
    end else if (clk_en) begin
      i_start_q <= 1'b0;
      d_start_q <= 1'b0;
      if (cfg_wr && unlocked) begin
        cfg_q <= reg_wdata;
        if (reg_wdata[FCC_D_ZERO]) begin
          cfg_q[FCC_D_FREEZE] <= 1'b0;
          cfg_q[FCC_D_ON]     <= 1'b0;
          d_start_q           <= 1'b1;
        end
        if (reg_wdata[FCC_I_ZERO]) begin
          cfg_q[FCC_I_FREEZE] <= 1'b0;
          cfg_q[FCC_I_ON]     <= 1'b0;
          i_start_q           <= 1'b1;
        end
      end else begin
        // fill bits drop as soon as the fill starts
        if (d_start_q) begin
          cfg_q[FCC_D_ZERO] <= 1'b0;
        end
        if (i_start_q) begin
          cfg_q[FCC_I_ZERO] <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // cache storage
  // ************************************************************
  fcc_cache_way u_icache (
    .clk        (clk),
    .arst_n     (arst_n),
    .clk_en     (clk_en),
    .fill_start (i_start_q),
    .cache_on   (i_use_cache),
    .freeze     (cfg_q[FCC_I_FREEZE]),
    .acc_valid  (i_valid),
    .acc_idx    (i_idx),
    .acc_fill   (i_fill),
    .acc_miss   (i_miss),
    .filling    (i_filling),
    .line_q     (i_line_w)
  );

  fcc_cache_way u_dcache (
    .clk        (clk),
    .arst_n     (arst_n),
    .clk_en     (clk_en),
    .fill_start (d_start_q),
    .cache_on   (d_use_cache),
    .freeze     (cfg_q[FCC_D_FREEZE]),
    .acc_valid  (d_valid),
    .acc_idx    (d_idx),
    .acc_fill   (d_fill),
    .acc_miss   (d_miss),
    .filling    (d_filling),
    .line_q     (d_line_w)
  );

  // ************************************************************
  // state report
  // ************************************************************
  // live state: fill busy forces the enable low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_q <= FCC_STATE_RST;
    end else if (clk_en) begin
      stat_q               <= '0;
      stat_q[FCC_D_FREEZE] <= cfg_q[FCC_D_FREEZE];
      stat_q[FCC_D_ON]     <= cfg_q[FCC_D_ON] && !d_filling && !d_start_q;
      stat_q[FCC_D_ZERO]   <= d_filling || d_start_q;
      stat_q[FCC_I_FREEZE] <= cfg_q[FCC_I_FREEZE];
      stat_q[FCC_I_ON]     <= cfg_q[FCC_I_ON] && !i_filling && !i_start_q;
      stat_q[FCC_I_ZERO]   <= i_filling || i_start_q;
    end
  end

  // ************************************************************
  // routing controls
  // ************************************************************
  // registered controls for the fetch and data paths
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      i_use_cache <= FCC_CONFIG_RST[FCC_I_ON];
      d_use_cache <= 1'b0;
      i_alloc_ok  <= 1'b0;
      d_alloc_ok  <= 1'b0;
      i_rbuf_skip <= 1'b0;
      i_wbuf_skip <= 1'b0;
      d_wbuf_skip <= 1'b0;
    end else if (clk_en) begin
      i_use_cache <= cfg_q[FCC_I_ON] && !i_filling && !i_start_q;
      d_use_cache <= cfg_q[FCC_D_ON] && !d_filling && !d_start_q;
      i_alloc_ok  <= !cfg_q[FCC_I_FREEZE];
      d_alloc_ok  <= !cfg_q[FCC_D_FREEZE];
      i_rbuf_skip <= cfg_q[FCC_I_RBUF_BIT];
      i_wbuf_skip <= cfg_q[FCC_I_WBUF_BIT];
      d_wbuf_skip <= cfg_q[FCC_D_WBUF_BIT];
    end
  end

  // cache lines out, registered once more
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      i_line <= '0;
      d_line <= '0;
    end else if (clk_en) begin
      i_line <= i_line_w;
      d_line <= d_line_w;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  // read data one cycle after the strobe, zero otherwise or unmapped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= '0;
      if (reg_rd) begin
        if (hit(reg_addr, FCC_ADDR_STATE)) begin
          reg_rdata <= stat_q;
        end else if (hit(reg_addr, FCC_ADDR_CONFIG)) begin
          reg_rdata <= cfg_q;
        end
        // unlock word always reads zero
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n || !clk_en);

  sequence s_locked_wr;
    reg_wr && hit(reg_addr, FCC_ADDR_CONFIG) && !unlocked;
  endsequence

  sequence s_unlock_then_cfg;
    key_wr && reg_wdata == FCC_UNLOCK_KEY ##[1:2] cfg_wr && unlocked;
  endsequence

  key_reads_zero_a: assert property (reg_rd && hit(reg_addr, FCC_ADDR_UNLOCK)
    |=> reg_rdata == 32'h0) else $error("unlock word read not zero");
  key_wipe_a: assert property (cfg_wr |=> key_q == 32'h0)
    else $error("unlock word kept after setup write");
  locked_wr_a: assert property (s_locked_wr |=> $stable(cfg_q) || $fell(cfg_q[FCC_D_ZERO])
    || $fell(cfg_q[FCC_I_ZERO])) else $error("locked setup write took effect");
  unlock_wr_a: assert property (s_unlock_then_cfg |=> cfg_q[FCC_D_WBUF_BIT]
    == $past(reg_wdata[FCC_D_WBUF_BIT])) else $error("unlocked setup write lost");
  dzero_clr_a: assert property (d_start_q |=> !cfg_q[FCC_D_ZERO] && !cfg_q[FCC_D_ON]
    && !cfg_q[FCC_D_FREEZE]) else $error("data fill bits not cleared");
  izero_clr_a: assert property (i_start_q |=> !cfg_q[FCC_I_ZERO] && !cfg_q[FCC_I_ON])
    else $error("instruction fill bits not cleared");
  d_stat_fill_a: assert property (d_start_q |=> stat_q[FCC_D_ZERO] && !stat_q[FCC_D_ON])
    else $error("data fill not reported");
  i_stat_fill_a: assert property (i_start_q |=> stat_q[FCC_I_ZERO] && !stat_q[FCC_I_ON]
    ##1 !stat_q[FCC_I_ON]) else $error("instruction fill not reported");
  d_lock_stat_a: assert property (##1 stat_q[FCC_D_FREEZE] == $past(cfg_q[FCC_D_FREEZE]))
    else $error("data freeze status wrong");
  i_lock_stat_a: assert property (##1 stat_q[FCC_I_FREEZE] == $past(cfg_q[FCC_I_FREEZE]))
    else $error("instruction freeze status wrong");
  bypass_map_a: assert property (##1 d_wbuf_skip == $past(cfg_q[FCC_D_WBUF_BIT])
    && i_rbuf_skip == $past(cfg_q[FCC_I_RBUF_BIT])) else $error("bypass mismatch");

endmodule : fcc_ctrl

// >>> fcc_cpu_model.sv
// processor side model: issues fetch and data accesses toward the cache control
`timescale 1ns/10ps
module fcc_cpu_model
  import fcc_pkg::*;
(
  // clock
  input  wire logic              clk,
  // fetch path
  output logic                   i_valid,
  output logic [FCC_IDX_W-1:0]   i_idx,
  output logic                   i_miss,
  output logic [FCC_LINE_W-1:0]  i_fill,
  // data path
  output logic                   d_valid,
  output logic [FCC_IDX_W-1:0]   d_idx,
  output logic                   d_miss,
  output logic [FCC_LINE_W-1:0]  d_fill
);
  // ************************************************************
  // idle levels at time zero
  // ************************************************************
  initial begin
    i_valid = 1'b0;
    d_valid = 1'b0;
    i_idx   = '0;
    d_idx   = '0;
    i_miss  = 1'b0;
    d_miss  = 1'b0;
    i_fill  = '0;
    d_fill  = '0;
  end

  // one access pulse on both paths; data path gets the inverted line
  // so a crossed path shows up as a mismatch
  task automatic access(input logic [FCC_IDX_W-1:0] idx, input logic miss,
                        input logic [FCC_LINE_W-1:0] fl);
    @(posedge clk);
    i_valid <= 1'b1;
    d_valid <= 1'b1;
    i_idx   <= idx;
    d_idx   <= idx;
    i_miss  <= miss;
    d_miss  <= miss;
    i_fill  <= fl;
    d_fill  <= ~fl;
    @(posedge clk);
    // released lines show the inverse, never the stale value
    i_valid <= 1'b0;
    d_valid <= 1'b0;
    i_idx   <= ~idx;
    d_idx   <= ~idx;
    i_miss  <= ~miss;
    d_miss  <= ~miss;
    i_fill  <= ~fl;
    d_fill  <= fl;
  endtask : access
endmodule : fcc_cpu_model

// >>> flash_cache_control_tb.sv
// self-checking testbench for the flash cache control
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, g, e); end end
module flash_cache_control_tb
  import fcc_pkg::*;
;
  // ************************************************************
  // signals
  // ************************************************************
  logic                  clk = 1'b0;
  logic                  arst_n = 1'b0;
  logic [31:0]           reg_addr = '0;
  logic [31:0]           reg_wdata = '0;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  logic [31:0]           reg_rdata;
  logic                  i_valid, i_miss, d_valid, d_miss;
  logic [FCC_IDX_W-1:0]  i_idx, d_idx;
  logic [FCC_LINE_W-1:0] i_fill, d_fill, i_line, d_line;
  logic                  i_use_cache, d_use_cache, i_alloc_ok, d_alloc_ok;
  logic                  i_rbuf_skip, i_wbuf_skip, d_wbuf_skip;
  logic [31:0]           v, cur, r;          // read value, expected setup, random word
  integer                seed = 99382;       // fixed seed
  int                    err_count = 0;
  int                    comparisons = 0;
  localparam logic [31:0] LINE_A = 32'h5a3c_c3a5;

  // ************************************************************
  // clock, design and partner
  // ************************************************************
  initial begin
    forever #2.5 clk = ~clk;
  end

  fcc_ctrl dut_u (.clk(clk), .arst_n(arst_n), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .i_valid(i_valid), .i_idx(i_idx), .i_miss(i_miss), .i_fill(i_fill), .i_line(i_line),
    .d_valid(d_valid), .d_idx(d_idx), .d_miss(d_miss), .d_fill(d_fill), .d_line(d_line),
    .i_use_cache(i_use_cache), .d_use_cache(d_use_cache), .i_alloc_ok(i_alloc_ok),
    .d_alloc_ok(d_alloc_ok), .i_rbuf_skip(i_rbuf_skip), .i_wbuf_skip(i_wbuf_skip),
    .d_wbuf_skip(d_wbuf_skip));

  fcc_cpu_model cpu_u (.clk(clk), .i_valid(i_valid), .i_idx(i_idx), .i_miss(i_miss),
    .i_fill(i_fill), .d_valid(d_valid), .d_idx(d_idx), .d_miss(d_miss), .d_fill(d_fill));

  // ************************************************************
  // bus tasks and expectations
  // ************************************************************
  // one-cycle write strobe
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  // key first, then the setup word
  task automatic setup(input logic [31:0] d);
    wr(FCC_ADDR_UNLOCK, FCC_UNLOCK_KEY);
    wr(FCC_ADDR_CONFIG, d);
  endtask : setup

  // a zero fill request clears its freeze, on and fill bits
  function automatic logic [31:0] exp_cfg(input logic [31:0] w);
    exp_cfg = w;
    if (w[16]) exp_cfg[18:16] = 3'h0;
    if (w[0]) exp_cfg[2:0] = 3'h0;
  endfunction : exp_cfg

  // read back setup and state, and check the routing outputs
  task automatic chk_cfg(input logic [31:0] e);
    rd(FCC_ADDR_CONFIG, v);
    `CHK(v, e)
    rd(FCC_ADDR_STATE, v);
    `CHK(v, e & 32'h0006_0006)
    `CHK({i_use_cache, d_use_cache, i_alloc_ok, d_alloc_ok}, {e[1], e[17], ~e[2], ~e[18]})
    `CHK({i_rbuf_skip, i_wbuf_skip, d_wbuf_skip}, {e[4], e[3], e[19]})
  endtask : chk_cfg

  // access one line, then read it back by a hit and compare both stored lines
  task automatic chk_line(input logic miss, input logic [31:0] fl, input logic [31:0] e);
    cpu_u.access(4'h5, miss, fl);
    cpu_u.access(4'h5, 1'b0, 32'h0);
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK({i_line, d_line}, {e, ~e})
  endtask : chk_line

  // verdict
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // ************************************************************
  // watchdog
  // ************************************************************
  initial begin
    #100000;
    err_count++;
    results();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    // reset values, write-only key, unmapped place
    rd(FCC_ADDR_STATE, v);
    `CHK(v, FCC_STATE_RST)
    rd(FCC_ADDR_CONFIG, v);
    `CHK(v, FCC_CONFIG_RST)
    wr(FCC_ADDR_UNLOCK, 32'h1234_5678);
    rd(FCC_ADDR_UNLOCK, v);
    `CHK(v, 32'h0)
    rd(32'h4001_80cc, v);
    `CHK(v, 32'h0)
    // wrong key and a write to the state report change nothing
    wr(FCC_ADDR_CONFIG, 32'h000e_001e);
    wr(FCC_ADDR_STATE, 32'hffff_ffff);
    chk_cfg(FCC_CONFIG_RST);
    // both caches on, a miss allocates
    setup(32'h0002_0002);
    chk_cfg(32'h0002_0002);
    chk_line(1'b1, LINE_A, LINE_A);
    // freeze, then a keyless write is refused
    setup(32'h0006_0006);
    wr(FCC_ADDR_CONFIG, 32'h0002_0002);
    chk_cfg(32'h0006_0006);
    chk_line(1'b1, ~LINE_A, LINE_A);
    chk_line(1'b0, 32'h0, LINE_A);
    // random setup words, some without a fresh key
    cur = 32'h0006_0006;
    for (int n = 0; n < 24; n++) begin
      r = $random(seed);
      v = r & ~32'h0001_0001;
      if (r[0]) begin
        setup(v);
        cur = v;
      end else begin
        wr(FCC_ADDR_CONFIG, v);
      end
      chk_cfg(cur);
    end
    // zero fill of both caches with every dependant set
    setup(32'h000f_001f);
    rd(FCC_ADDR_CONFIG, v);
    `CHK(v, exp_cfg(32'h000f_001f))
    rd(FCC_ADDR_STATE, v);
    `CHK(v, 32'h0001_0001)
    for (int n = 0; n < 40 && v !== 32'h0; n++) begin
      rd(FCC_ADDR_STATE, v);
    end
    `CHK(v, 32'h0)
    chk_cfg(32'h0008_0018);
    // caches back on: the filled line now reads zero
    setup(32'h0002_0002);
    cpu_u.access(4'h5, 1'b0, LINE_A);
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK({i_line, d_line}, 64'h0)
    results();
  end
endmodule : flash_cache_control_tb
